// file: hw/backlight_scratch_pkg.sv
// Shared constants and carrier types for the backlight and scratch register bank
`default_nettype none
package backlight_scratch_pkg;

  localparam int unsigned CFG_AW        = 8;
  localparam int unsigned CFG_DW        = 32;
  localparam int unsigned CFG_BYTES     = 4;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned WORD_LSB      = 2;

  // Register byte offsets in configuration space
  localparam logic [CFG_AW-1:0] BACKLIGHT_OFF = 8'hf4;
  localparam logic [CFG_AW-1:0] SCRATCH_OFF   = 8'hfc;

  // Reset values
  localparam logic [CFG_DW-1:0] BACKLIGHT_RST = 32'h0000_0000;
  localparam logic [CFG_DW-1:0] SCRATCH_RST   = 32'h0000_0000;
  localparam logic [CFG_DW-1:0] UNMAPPED_DATA = 32'h0000_0000;

  // Brightness field in the low byte
  localparam int unsigned BRIGHT_LSB = 0;
  localparam int unsigned BRIGHT_MSB = 7;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [CFG_AW-1:0]    addr;
    logic [CFG_BYTES-1:0] be;
    logic [CFG_DW-1:0]    wdata;
  } cfg_req_t;

  typedef struct packed {
    logic              rvalid;
    logic [CFG_DW-1:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic event_enable;
    logic irq_enable;
    logic irq_mask;
  } event_gate_t;

endpackage
`default_nettype wire

// file: hw/byte_lane_reg.sv
// Word register with per-byte write enables
`default_nettype none
module byte_lane_reg
  import backlight_scratch_pkg::*;
#(
  parameter logic [CFG_DW-1:0] RST_VAL = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Write side
  input  wire logic                 wr_en,
  input  wire logic [CFG_BYTES-1:0] be,
  input  wire logic [CFG_DW-1:0]    wdata,
  // Stored value
  output logic      [CFG_DW-1:0]    value_ff
);

  genvar g;
  generate
    for (g = 0; g < CFG_BYTES; g++) begin : g_lane
      // Lanes left out of a write hold their contents
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          value_ff[g*BYTE_W +: BYTE_W] <= RST_VAL[g*BYTE_W +: BYTE_W];
        end else if (wr_en && be[g]) begin
          value_ff[g*BYTE_W +: BYTE_W] <= wdata[g*BYTE_W +: BYTE_W];
        end
      end
    end
  endgenerate

endmodule // byte_lane_reg
`default_nettype wire

// file: hw/backlight_scratch_regs.sv
// Backlight level/trigger and firmware scratch configuration registers
//
// Functional notes
// - Backlight register accepts byte, word or dword access per byte enables.
// - Any backlight register write with at least one byte enable set raises the backlight event if enabled.
// - Event fires only when event enabled, irq enabled and irq unmasked.
// - One multi-byte write yields exactly one event, not one per byte.
// - Low byte is brightness: zero dimmest, 255 brightest.
// - Scratch register is full read/write, resets to zero, no hardware effect.
// - Bytes not enabled by a write keep their previous value.
`default_nettype none
module backlight_scratch_regs
  import backlight_scratch_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Configuration cycles
  input  wire cfg_req_t             cfg_req,
  output cfg_rsp_t                  cfg_rsp_ff,
  // Display interrupt gating
  input  wire event_gate_t          evt_gate,
  // Display interrupt event and brightness level
  output logic                      backlight_event_ff,
  output logic [BYTE_W-1:0]         brightness_ff
);

  // Byte lane that carries the brightness field
  localparam int unsigned BRIGHT_LANE = BRIGHT_LSB / BYTE_W;

  function automatic logic word_hit(input logic [CFG_AW-1:0] addr,
                                    input logic [CFG_AW-1:0] off);
    word_hit = (addr[CFG_AW-1:WORD_LSB] == off[CFG_AW-1:WORD_LSB]);
  endfunction

  // Decode
  wire logic              bl_sel;
  wire logic              scr_sel;
  wire logic              bl_wr;
  wire logic              scr_wr;
  wire logic              any_lane;
  wire logic              gate_open;
  wire logic              nxt_event;
  wire logic [CFG_DW-1:0] bl_value;
  wire logic [CFG_DW-1:0] scr_value;
  wire logic [CFG_DW-1:0] nxt_rdata;

  assign bl_sel    = word_hit(cfg_req.addr, BACKLIGHT_OFF);
  assign scr_sel   = word_hit(cfg_req.addr, SCRATCH_OFF);
  assign any_lane  = |cfg_req.be;
  assign bl_wr     = cfg_req.wr && bl_sel;
  assign scr_wr    = cfg_req.wr && scr_sel;
  // Gate is sampled with the write so a late enable change cannot split it
  assign gate_open = evt_gate.event_enable && evt_gate.irq_enable && !evt_gate.irq_mask;
  // One event per write, however many lanes it carries
  assign nxt_event = bl_wr && any_lane && gate_open;

  assign nxt_rdata = bl_sel  ? bl_value :
                     scr_sel ? scr_value : UNMAPPED_DATA;

  byte_lane_reg #(
    .RST_VAL (BACKLIGHT_RST)
  ) u_backlight (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (bl_wr),
    .be       (cfg_req.be),
    .wdata    (cfg_req.wdata),
    .value_ff (bl_value)
  );

  // Contents feed only the read path
  byte_lane_reg #(
    .RST_VAL (SCRATCH_RST)
  ) u_scratch (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (scr_wr),
    .be       (cfg_req.be),
    .wdata    (cfg_req.wdata),
    .value_ff (scr_value)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      backlight_event_ff <= 1'b0;
    end else begin
      backlight_event_ff <= nxt_event;
    end
  end

  // Brightness mirror kept as its own flop so the output stays registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brightness_ff <= BACKLIGHT_RST[BRIGHT_MSB:BRIGHT_LSB];
    end else if (bl_wr && cfg_req.be[BRIGHT_LANE]) begin
      brightness_ff <= cfg_req.wdata[BRIGHT_MSB:BRIGHT_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp_ff <= '0;
    end else begin
      cfg_rsp_ff.rvalid <= cfg_req.rd;
      cfg_rsp_ff.rdata  <= cfg_req.rd ? nxt_rdata : UNMAPPED_DATA;
    end
  end

  chk_event_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    backlight_event_ff |-> $past(cfg_req.wr && bl_sel && any_lane))
    else $error("backlight event without a backlight write");

  chk_event_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && bl_sel && any_lane && !gate_open) |=> !backlight_event_ff)
    else $error("backlight event raised while gated off");

  chk_event_fires: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && bl_sel && any_lane && gate_open) |=> backlight_event_ff)
    else $error("enabled backlight write raised no event");

  chk_single_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && bl_sel && (&cfg_req.be) && gate_open) ##1 !cfg_req.wr |=>
      !backlight_event_ff)
    else $error("dword write raised more than one event");

  chk_bright_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && bl_sel && cfg_req.be[BRIGHT_LANE]) |=>
      brightness_ff == $past(cfg_req.wdata[BRIGHT_MSB:BRIGHT_LSB]) &&
      bl_value[BRIGHT_MSB:BRIGHT_LSB] == brightness_ff)
    else $error("brightness byte not taken from write");

  // Every lane is checked, not one sample lane
  generate
    for (genvar l = 0; l < CFG_BYTES; l++) begin : g_lane_chk
      chk_lane_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bl_wr && cfg_req.be[l]) |=>
          bl_value[l*BYTE_W +: BYTE_W] == $past(cfg_req.wdata[l*BYTE_W +: BYTE_W]))
        else $error("enabled backlight byte not written");

      chk_lane_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(cfg_req.wr && cfg_req.be[l]) |=>
          $stable(bl_value[l*BYTE_W +: BYTE_W]) && $stable(scr_value[l*BYTE_W +: BYTE_W]))
        else $error("disabled byte lane changed");

      chk_scratch_lane: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scr_wr && cfg_req.be[l]) |=>
          scr_value[l*BYTE_W +: BYTE_W] == $past(cfg_req.wdata[l*BYTE_W +: BYTE_W]))
        else $error("enabled scratch byte not written");
    end
  endgenerate

  chk_scratch_rw: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && scr_sel && (&cfg_req.be)) ##1 cfg_req.rd && scr_sel && !cfg_req.wr |=>
      cfg_rsp_ff.rvalid && cfg_rsp_ff.rdata == $past(cfg_req.wdata, 2))
    else $error("scratch read-back mismatch");

  chk_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.rd && bl_sel) |=> cfg_rsp_ff.rvalid && cfg_rsp_ff.rdata == $past(bl_value))
    else $error("backlight read-back mismatch");

  // Event shape
  chk_event_gate_past: assert property (@(posedge core_clk) disable iff (!rst_n)
    backlight_event_ff |-> $past(gate_open))
    else $error("backlight event without an open gate");

  chk_empty_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && bl_sel && !any_lane) |=>
      !backlight_event_ff)
    else $error("write with no byte enables raised an event");

  chk_event_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (backlight_event_ff && !(cfg_req.wr && bl_sel)) |=>
      !backlight_event_ff)
    else $error("backlight event stretched past one cycle");

  chk_scratch_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.wr && scr_sel) |=>
      !backlight_event_ff)
    else $error("scratch write raised a backlight event");

  // Stored values move only under a write
  chk_backlight_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bl_wr |=> $stable(bl_value))
    else $error("backlight register changed without a write");

  chk_scratch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !scr_wr |=> $stable(scr_value))
    else $error("scratch register changed without a write");

  chk_bright_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(bl_wr && cfg_req.be[BRIGHT_LANE]) |=>
      $stable(brightness_ff))
    else $error("brightness changed without a low byte write");

  chk_bright_mirror: assert property (@(posedge core_clk) disable iff (!rst_n)
    brightness_ff == bl_value[BRIGHT_MSB:BRIGHT_LSB])
    else $error("brightness output differs from stored low byte");

  // Read response shape
  // Idle response is zero so a stale word never looks like a fresh read
  chk_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg_req.rd |=>
      !cfg_rsp_ff.rvalid && cfg_rsp_ff.rdata == UNMAPPED_DATA)
    else $error("read response outside a read");

  chk_scratch_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.rd && scr_sel) |=>
      cfg_rsp_ff.rvalid && cfg_rsp_ff.rdata == $past(scr_value))
    else $error("scratch read data mismatch");

  chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_req.rd && !bl_sel && !scr_sel) |=>
      cfg_rsp_ff.rvalid && cfg_rsp_ff.rdata == UNMAPPED_DATA)
    else $error("unmapped read returned data");

  // Writes get no answer on the read path
  chk_write_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_req.wr |=> !cfg_rsp_ff.rvalid)
    else $error("write produced a read response");

endmodule // backlight_scratch_regs
`default_nettype wire

// file: sim/cfg_host_model.sv
// Host model driving configuration cycles
`default_nettype none
module cfg_host_model
  import backlight_scratch_pkg::*;
(
  // Clock
  input  wire logic     core_clk,
  // Configuration cycles
  output var cfg_req_t  cfg_req,
  input  wire cfg_rsp_t cfg_rsp_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cfg_req = '0;
  task automatic wr(input logic [CFG_AW-1:0] a, input logic [CFG_BYTES-1:0] b, input logic [CFG_DW-1:0] d);
    cfg_req <= {1'b1, 1'b0, a, b, d};
    @(posedge core_clk);
  endtask
  // Released lines flip so stale data never passes for a live request
  task automatic idle();
    cfg_req <= {1'b0, 1'b0, ~cfg_req.addr, ~cfg_req.be, ~cfg_req.wdata};
  endtask
  task automatic rd(input logic [CFG_AW-1:0] a, output logic [CFG_DW-1:0] d, output logic v);
    cfg_req <= {1'b0, 1'b1, a, ~cfg_req.be, ~cfg_req.wdata};
    @(posedge core_clk);
    idle();
    @(negedge core_clk);
    d = cfg_rsp_ff.rdata;
    v = cfg_rsp_ff.rvalid;
    @(posedge core_clk);
  endtask
endmodule // cfg_host_model
`default_nettype wire

// file: sim/backlight_scratch_regs_tb_top.sv
// Self-checking testbench for the backlight and scratch register bank
`default_nettype none
module backlight_scratch_regs_tb_top import backlight_scratch_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  cfg_req_t          cfg_req;
  cfg_rsp_t          cfg_rsp_ff;
  event_gate_t       evt_gate = 3'b110;
  logic              backlight_event_ff;
  logic [BYTE_W-1:0] brightness_ff;
  logic [CFG_DW-1:0] rdat;
  logic              rv;
  int                n_fail = 0, checks_done = 0, n_evt = 0, cycles = 0;

  backlight_scratch_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp_ff(cfg_rsp_ff),
    .evt_gate(evt_gate), .backlight_event_ff(backlight_event_ff), .brightness_ff(brightness_ff));
  cfg_host_model host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_rsp_ff(cfg_rsp_ff));

  initial forever #2.5 core_clk = ~core_clk;
  // Counting pulses catches both missing and stretched events
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (backlight_event_ff === 1'b1) n_evt <= n_evt + 1;
    if (cycles == 2000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic chk(input logic [CFG_DW-1:0] seen, input logic [CFG_DW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_evt(input logic [CFG_AW-1:0] a, input logic [CFG_BYTES-1:0] b, input logic [CFG_DW-1:0] d,
                        input int e);
    int n0;
    n0 = n_evt;
    host.wr(a, b, d);
    host.idle();
    repeat (2) @(negedge core_clk);
    chk(n_evt - n0, e);
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [CFG_AW-1:0] a, input logic [CFG_DW-1:0] e);
    host.rd(a, rdat, rv);
    chk({31'h0, rv}, 32'h1);
    chk(rdat, e);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(BACKLIGHT_OFF, 32'h0);
    rd_chk(SCRATCH_OFF, 32'h0);
    wr_evt(BACKLIGHT_OFF, 4'hf, 32'h1234_5678, 1);
    rd_chk(BACKLIGHT_OFF, 32'h1234_5678);
    chk({24'h0, brightness_ff}, 32'h78);
    wr_evt(BACKLIGHT_OFF, 4'h1, 32'h0000_00ff, 1);
    chk({24'h0, brightness_ff}, 32'hff);
    wr_evt(BACKLIGHT_OFF, 4'h2, 32'haabb_ccdd, 1);
    wr_evt(BACKLIGHT_OFF, 4'hc, 32'h9988_7766, 1);
    wr_evt(BACKLIGHT_OFF, 4'h0, 32'hffff_ffff, 0);
    rd_chk(BACKLIGHT_OFF, 32'h9988_ccff);
    for (int g = 0; g < 8; g++) begin
      evt_gate <= g[2:0];
      @(posedge core_clk);
      wr_evt(BACKLIGHT_OFF, 4'h8, 32'h9900_0000, int'(g == 6));
    end
    evt_gate <= 3'b110;
    @(posedge core_clk);
    host.wr(BACKLIGHT_OFF, 4'h3, 32'h0000_0100);
    wr_evt(BACKLIGHT_OFF, 4'h1, 32'h0, 2);
    rd_chk(BACKLIGHT_OFF, 32'h9988_0100);
    chk({24'h0, brightness_ff}, 32'h0);
    wr_evt(SCRATCH_OFF, 4'hf, 32'hdead_beef, 0);
    wr_evt(SCRATCH_OFF, 4'h4, 32'h0011_2233, 0);
    rd_chk(SCRATCH_OFF, 32'hde11_beef);
    host.wr(SCRATCH_OFF, 4'hf, 32'h0f1e_2d3c);
    rd_chk(SCRATCH_OFF, 32'h0f1e_2d3c);
    wr_evt(8'hf8, 4'hf, 32'hffff_ffff, 0);
    rd_chk(8'hf8, UNMAPPED_DATA);
    summarize();
  end
endmodule // backlight_scratch_regs_tb_top
`default_nettype wire
